// ### hdl/byte_rotate_consts.svh
// Constants for the byte rotate unit: opcode codes and reset values.
// Assumes inclusion by bare name from design files.
`ifndef BYTE_ROTATE_CONSTS_SVH
`define BYTE_ROTATE_CONSTS_SVH
`define ROT_OP_LEFT_TO_ACC 3'h1
`define ROT_OP_LEFT_THRU_CARRY 3'h2
`define ROT_OP_LEFT_THRU_CARRY_TO_ACC 3'h3
`define ROT_OP_RIGHT_MEM 3'h4
`define ROT_OP_RIGHT_TO_ACC 3'h5
`define ROT_OP_RIGHT_THRU_CARRY 3'h6
`define ROT_ACC_RESET 8'h00
`define ROT_WR_DATA_RESET 8'h00
`define ROT_CARRY_RESET 1'h0
`define ROT_MSB 7
`define ROT_LSB 0
`endif

// ### hdl/byte_rotate_pkg.sv
// Types for the byte rotate unit.
// Assumes the constants header sits beside it.
package byte_rotate_pkg;
   typedef logic [2:0] rot_op_t;
   typedef logic [7:0] rot_byte_t;
endpackage

// ### hdl/byte_rotate_unit.sv
// Byte rotate datapath: six rotate forms on a data memory byte.
// Assumes the decoder pulses op_valid with op_code and rd_data stable in that cycle.
//
// Operation
// (RULE1) Left rotate into accumulator, bit 7 wraps to bit 0, flags kept.
// (RULE2) Left rotate through carry, written back, carry takes old bit 7.
// (RULE3) Left rotate through carry into accumulator, carry takes old bit 7.
// (RULE4) Right rotate written back, bit 0 wraps to bit 7, flags kept.
// (RULE5) Right rotate into accumulator, bit 0 wraps to bit 7, flags kept.
// (RULE6) Right rotate through carry, written back, carry takes old bit 0.
// (RULE7) One read-modify-write per instruction; carry updates with the result.
`timescale 1ns/1ps
`default_nettype none
`include "byte_rotate_consts.svh"
module byte_rotate_unit
   import byte_rotate_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic op_valid,
   input wire logic [2:0] op_code,
   input wire logic [7:0] rd_data,
   output logic [7:0] wr_data,
   output logic wr_en,
   output logic [7:0] acc,
   output logic carry,
   output logic done
);
   function automatic logic op_writes_mem(input logic [2:0] op);
      op_writes_mem = (op == `ROT_OP_LEFT_THRU_CARRY) || (op == `ROT_OP_RIGHT_MEM) ||
                      (op == `ROT_OP_RIGHT_THRU_CARRY);
   endfunction

   function automatic logic op_writes_acc(input logic [2:0] op);
      op_writes_acc = (op == `ROT_OP_LEFT_TO_ACC) || (op == `ROT_OP_LEFT_THRU_CARRY_TO_ACC) ||
                      (op == `ROT_OP_RIGHT_TO_ACC);
   endfunction

   function automatic logic op_uses_carry(input logic [2:0] op);
      op_uses_carry = (op == `ROT_OP_LEFT_THRU_CARRY) || (op == `ROT_OP_LEFT_THRU_CARRY_TO_ACC) ||
                      (op == `ROT_OP_RIGHT_THRU_CARRY);
   endfunction

   rot_byte_t result_d;
   logic carry_d;
   logic [7:0] wr_data_q;
   logic wr_en_q;
   logic [7:0] acc_q;
   logic carry_q;
   logic done_q;

   always_comb
   begin
      result_d = rd_data;
      carry_d = carry_q;
      // Old carry feeds the shift; the new one lands at the same edge
      unique case (op_code)
         // (RULE1) Plain left rotate
         `ROT_OP_LEFT_TO_ACC:
         begin
            result_d = {rd_data[6:0], rd_data[`ROT_MSB]};
         end
         // (RULE2) Left through carry
         `ROT_OP_LEFT_THRU_CARRY:
         begin
            result_d = {rd_data[6:0], carry_q};
            carry_d = rd_data[`ROT_MSB];
         end
         // (RULE3) Left through carry to acc
         `ROT_OP_LEFT_THRU_CARRY_TO_ACC:
         begin
            result_d = {rd_data[6:0], carry_q};
            carry_d = rd_data[`ROT_MSB];
         end
         // (RULE4) Plain right rotate
         `ROT_OP_RIGHT_MEM:
         begin
            result_d = {rd_data[`ROT_LSB], rd_data[7:1]};
         end
         // (RULE5) Right rotate to acc
         `ROT_OP_RIGHT_TO_ACC:
         begin
            result_d = {rd_data[`ROT_LSB], rd_data[7:1]};
         end
         // (RULE6) Right through carry
         `ROT_OP_RIGHT_THRU_CARRY:
         begin
            result_d = {carry_q, rd_data[7:1]};
            carry_d = rd_data[`ROT_LSB];
         end
         // Unassigned codes are ignored: no write, no flag change
         default:
         begin
            result_d = rd_data;
            carry_d = carry_q;
         end
      endcase
   end

   // Data holds between writes; only wr_en marks a new byte
   // (RULE7) Single write-back per op
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_en_q <= 1'h0;
         wr_data_q <= `ROT_WR_DATA_RESET;
      end
      else
      begin
         wr_en_q <= op_valid && op_writes_mem(op_code);
         if (op_valid && op_writes_mem(op_code))
         begin
            wr_data_q <= result_d;
         end
      end
   end

   // (RULE1) Accumulator load, memory untouched
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         acc_q <= `ROT_ACC_RESET;
      end
      else if (op_valid && op_writes_acc(op_code))
      begin
         acc_q <= result_d;
      end
   end

   // (RULE7) Carry moves with the result
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         carry_q <= `ROT_CARRY_RESET;
      end
      else if (op_valid && op_uses_carry(op_code))
      begin
         carry_q <= carry_d;
      end
   end

   // Done pulses for ignored codes too, so the decoder never waits
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         done_q <= 1'h0;
      end
      else
      begin
         done_q <= op_valid;
      end
   end

   // Every output straight from a flip-flop
   assign wr_data = wr_data_q;
   assign wr_en = wr_en_q;
   assign acc = acc_q;
   assign carry = carry_q;
   assign done = done_q;

   // Value checks, one per rotate form
   a_left_acc_value: assert property (@(posedge clk) disable iff (reset) // (RULE1)
      op_valid && op_code == `ROT_OP_LEFT_TO_ACC |=> acc == {$past(rd_data[6:0]), $past(rd_data[7])}
      && !wr_en && carry == $past(carry))
      else $error("left rotate to acc wrong");

   a_left_carry_mem: assert property (@(posedge clk) disable iff (reset) // (RULE2)
      op_valid && op_code == `ROT_OP_LEFT_THRU_CARRY |=> wr_en && wr_data == {$past(rd_data[6:0]), $past(carry)}
      && carry == $past(rd_data[7]))
      else $error("left through carry write wrong");

   a_left_carry_acc: assert property (@(posedge clk) disable iff (reset) // (RULE3)
      op_valid && op_code == `ROT_OP_LEFT_THRU_CARRY_TO_ACC |=> !wr_en && carry == $past(rd_data[7])
      && acc == {$past(rd_data[6:0]), $past(carry)})
      else $error("left through carry to acc wrong");

   a_right_mem_value: assert property (@(posedge clk) disable iff (reset) // (RULE4)
      op_valid && op_code == `ROT_OP_RIGHT_MEM |=> wr_en && wr_data == {$past(rd_data[0]), $past(rd_data[7:1])}
      && $stable(carry))
      else $error("right rotate write wrong");

   a_right_acc_value: assert property (@(posedge clk) disable iff (reset) // (RULE5)
      op_valid && op_code == `ROT_OP_RIGHT_TO_ACC |=> !wr_en && $stable(carry)
      && acc == {$past(rd_data[0]), $past(rd_data[7:1])})
      else $error("right rotate to acc wrong");

   a_right_carry_mem: assert property (@(posedge clk) disable iff (reset) // (RULE6)
      op_valid && op_code == `ROT_OP_RIGHT_THRU_CARRY |=> wr_en && carry == $past(rd_data[0])
      && wr_data == {$past(carry), $past(rd_data[7:1])})
      else $error("right through carry write wrong");

   a_plain_carry: assert property (@(posedge clk) disable iff (reset) // (RULE4)
      op_valid && !op_uses_carry(op_code) |=> $stable(carry))
      else $error("carry moved on a plain rotate");

   // Bookkeeping checks on pulses and held state
   a_write_single: assert property (@(posedge clk) disable iff (reset) // (RULE7)
      wr_en |-> done && $past(op_valid))
      else $error("write without an op");

   // A short reset may clear carry, which is a cause of its own
   a_carry_cause: assert property (@(posedge clk) disable iff (reset) // (RULE7)
      carry != $past(carry) |-> $past(reset) || ($past(op_valid) && $past(op_uses_carry(op_code))))
      else $error("carry changed without through-carry op");

   a_done_follows: assert property (@(posedge clk) disable iff (reset) // (RULE7)
      done == ($past(op_valid) && !$past(reset)))
      else $error("done not one cycle after op");

   a_acc_kept: assert property (@(posedge clk) disable iff (reset) // (RULE7)
      !(op_valid && op_writes_acc(op_code)) |=> $stable(acc))
      else $error("acc changed without acc op");

   a_ignored_code: assert property (@(posedge clk) disable iff (reset) // (RULE7)
      op_valid && !op_writes_mem(op_code) && !op_writes_acc(op_code)
      |=> !wr_en && done && $stable(acc) && $stable(carry))
      else $error("ignored code changed state");

   a_wr_data_held: assert property (@(posedge clk) disable iff (reset) // (RULE7)
      !wr_en && !$past(reset) |-> $stable(wr_data))
      else $error("write data moved without a write");

   a_reset_clears: assert property (@(posedge clk) // (RULE7)
      reset |=> !wr_en && !done && wr_data == `ROT_WR_DATA_RESET && acc == `ROT_ACC_RESET
      && carry == `ROT_CARRY_RESET)
      else $error("reset left state behind");
endmodule
`default_nettype wire

// ### verif/rot_mem_model.sv
// Data memory stand-in: one byte, written by wr_en or a bench load.
// Assumes the unit samples rd_data only with op_valid.
`timescale 1ns/1ps
`default_nettype none
module rot_mem_model (
   input wire logic clk,
   input wire logic op_valid,
   input wire logic load,
   input wire logic [7:0] load_data,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   logic [7:0] mem_q = 8'h00;
   // Unselected bus shows junk, never the stale byte
   assign rd_data = op_valid ? mem_q : ~mem_q;
   always @(posedge clk)
      if (load)
         mem_q <= load_data;
      else if (wr_en)
         mem_q <= wr_data;
endmodule
`default_nettype wire

// ### verif/tb_byte_rotate_unit.sv
// Bench for the rotate unit: every op code on random bytes, queued checks.
// Assumes rot_mem_model as the memory side.
`timescale 1ns/1ps
`default_nettype none
`include "byte_rotate_consts.svh"
module tb_byte_rotate_unit;
   logic clk = 1'b0, reset = 1'b1, op_valid = 1'b0, load = 1'b0;
   logic [2:0] op_code = 3'h0;
   logic [7:0] load_data = 8'h00, rd_data, wr_data, acc, mem_m = 8'h00, acc_m = 8'h00;
   logic wr_en, carry, done, c_m = 1'b0;
   logic [17:0] q[$];
   int seed = 32'hB027F63F, num_errors = 0, checked = 0, cycles = 0, ops = 0, dones = 0;
   wire logic [17:0] seen = {wr_en, wr_en ? wr_data : 8'h00, acc, carry};
   always #5 clk = ~clk;
   byte_rotate_unit i_byte_rotate_unit (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
      .rd_data(rd_data), .wr_data(wr_data), .wr_en(wr_en), .acc(acc), .carry(carry), .done(done));
   rot_mem_model i_rot_mem_model (.clk(clk), .op_valid(op_valid), .load(load), .load_data(load_data),
      .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data));
   task automatic check_res(input string name, input logic [17:0] e, input logic [17:0] s);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, e, s);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d of %0d checks", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Note expected result, issue one op; idle a cycle after writes
   task automatic do_op(input logic [2:0] code);
      logic w;
      logic [7:0] r, lc, rc;
      w = 1'b0;
      r = 8'h00;
      lc = {mem_m[6:0], c_m};
      rc = {c_m, mem_m[7:1]};
      case (code)
         `ROT_OP_LEFT_TO_ACC: acc_m = {mem_m[6:0], mem_m[7]};
         `ROT_OP_LEFT_THRU_CARRY: {c_m, r, w} = {mem_m[7], lc, 1'b1};
         `ROT_OP_LEFT_THRU_CARRY_TO_ACC: {c_m, acc_m} = {mem_m[7], lc};
         `ROT_OP_RIGHT_MEM: {r, w} = {mem_m[0], mem_m[7:1], 1'b1};
         `ROT_OP_RIGHT_TO_ACC: acc_m = {mem_m[0], mem_m[7:1]};
         `ROT_OP_RIGHT_THRU_CARRY: {c_m, r, w} = {mem_m[0], rc, 1'b1};
         default: ;
      endcase
      if (w)
         mem_m = r;
      q.push_back({w, r, acc_m, c_m});
      ops++;
      op_valid = 1'b1;
      op_code = code;
      @(negedge clk);
      if (w)
      begin
         op_valid = 1'b0;
         @(negedge clk);
      end
   endtask
   always @(negedge clk)
      if (done === 1'b1)
      begin
         dones++;
         check_res("result", q.pop_front(), seen);
      end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         num_errors++;
         complete_run();
      end
   end
   initial
   begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      check_res("reset", 18'h0, {wr_en, wr_data, acc, carry});
      for (int i = 0; i < 96; i++)
      begin
         // Mid-run reset: memory keeps its byte, unit state clears
         if (i == 48)
         begin
            op_valid = 1'b0;
            reset = 1'b1;
            repeat (2) @(negedge clk);
            reset = 1'b0;
            {acc_m, c_m} = 9'h000;
            check_res("reset", 18'h0, {wr_en, wr_data, acc, carry});
         end
         if ($random(seed) & 1)
         begin
            op_valid = 1'b0;
            load = 1'b1;
            load_data = 8'($random(seed));
            mem_m = load_data;
            @(negedge clk);
            load = 1'b0;
         end
         do_op(i[2:0]);
      end
      op_valid = 1'b0;
      repeat (3) @(negedge clk);
      check_res("pending", 18'h0, 18'(q.size()));
      check_res("done count", 18'(ops), 18'(dones));
      complete_run();
   end
endmodule
`default_nettype wire
